// ==== common/startup_regs.svh ====
/*
 * Constants for the start-up and auto-baud sequencer: timing, protocol bytes, limits.
 * Assumes a 20 MHz system clock; included by design and bench files.
 */
// Functional notes
// - Host sends 0x55, device answers 0x06
// - Serial port starts at 9600 bps
// - Screen blank, wait 5s for auto-baud
// - No auto-baud by timeout: show splash
// - Run card auto-run script at power-up
// - Accept volume only 8 through 127
// - Audio plays alongside command execution
// - Byte address 2^32, sector address 2^24
// - Firmware loads over serial port only
// - ACK 0x06 success, NAK 0x15 failure/unknown
// - Frame: start, 8 data LSB first, stop
`ifndef STARTUP_REGS_SVH
`define STARTUP_REGS_SVH
`define CLK_HZ 20000000
`define DEF_BAUD 9600
`define BIT_CYCLES (`CLK_HZ / `DEF_BAUD)
`define SETTLE_MS 500
`define SPLASH_WAIT_MS 5000
`define MS_CYCLES (`CLK_HZ / 1000)
`define SETTLE_CYCLES (`SETTLE_MS * `MS_CYCLES)
`define SPLASH_CYCLES (`SPLASH_WAIT_MS * `MS_CYCLES)
`define BYTE_AUTOBAUD 8'h55
`define BYTE_ACK 8'h06
`define BYTE_NAK 8'h15
`define VOL_MIN 7'h08
`define VOL_MAX 7'h7F
`define CMD_SET_VOLUME 8'h76
`define CMD_FW_LOAD 8'h70
`define CMD_PLAY_AUDIO 8'h6C
`define VOL_RESET 7'h40
`endif

// ==== common/startup_pkg.sv ====
/*
 * Types for the start-up sequencer.
 * Assumes startup_regs.svh supplies the constants.
 */
package startup_pkg;
    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_WAIT_BAUD,
        ST_SPLASH,
        ST_RUN
    } seq_state_t;
    typedef enum logic [1:0] {
        CP_IDLE,
        CP_VOLUME
    } cmd_state_t;
endpackage

// ==== design/serial_byte_port.sv ====
/*
 * Byte-wide asynchronous serial receiver and transmitter, 8N1.
 * Assumes rx_pin is asynchronous; tx_start only while tx_busy is low.
 */
`timescale 1ns/100ps
`include "startup_regs.svh"
module serial_byte_port #(
    parameter int BIT_CYC = `BIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    output logic tx_busy
);
    logic rx_s1_ff, rx_s2_ff;
    logic [15:0] rx_cnt_ff, nxt_rx_cnt;
    logic [3:0] rx_bit_ff, nxt_rx_bit;
    logic [7:0] rx_sh_ff, nxt_rx_sh;
    logic rx_act_ff, nxt_rx_act, rx_vld_ff, nxt_rx_vld;
    logic [15:0] tx_cnt_ff, nxt_tx_cnt;
    logic [3:0] tx_bit_ff, nxt_tx_bit;
    logic [9:0] tx_sh_ff, nxt_tx_sh;
    logic tx_act_ff, nxt_tx_act;
    localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYC / 2);

    // ****************
    // Receiver
    // ****************
    always_comb begin
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_act = rx_act_ff;
        nxt_rx_vld = 1'b0;
        if (!rx_act_ff) begin
            if (!rx_s2_ff) begin
                nxt_rx_act = 1'b1;
                nxt_rx_cnt = HALF;
                nxt_rx_bit = 4'h0;
            end
        end else if (rx_cnt_ff != 16'h0000) begin
            nxt_rx_cnt = rx_cnt_ff - 16'h0001;
        end else begin
            nxt_rx_cnt = FULL;
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'h0) begin
                // False start: line went back high at mid start bit
                if (rx_s2_ff) nxt_rx_act = 1'b0;
            end else if (rx_bit_ff < 4'h9) begin
                nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
            end else begin
                nxt_rx_act = 1'b0;
                nxt_rx_vld = rx_s2_ff;
            end
        end
    end

    // ****************
    // Transmitter
    // ****************
    always_comb begin
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_act = tx_act_ff;
        if (!tx_act_ff) begin
            if (tx_start) begin
                nxt_tx_act = 1'b1;
                nxt_tx_sh = {1'b1, tx_data, 1'b0};
                nxt_tx_cnt = FULL;
                nxt_tx_bit = 4'h0;
            end
        end else if (tx_cnt_ff != 16'h0000) begin
            nxt_tx_cnt = tx_cnt_ff - 16'h0001;
        end else begin
            nxt_tx_cnt = FULL;
            nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
            nxt_tx_bit = tx_bit_ff + 4'h1;
            if (tx_bit_ff == 4'h9) nxt_tx_act = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_cnt_ff <= 16'h0000;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            rx_act_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
            tx_cnt_ff <= 16'h0000;
            tx_bit_ff <= 4'h0;
            tx_sh_ff <= 10'h3FF;
            tx_act_ff <= 1'b0;
        end else begin
            rx_s1_ff <= rx_pin;
            rx_s2_ff <= rx_s1_ff;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_bit_ff <= nxt_rx_bit;
            rx_sh_ff <= nxt_rx_sh;
            rx_act_ff <= nxt_rx_act;
            rx_vld_ff <= nxt_rx_vld;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_bit_ff <= nxt_tx_bit;
            tx_sh_ff <= nxt_tx_sh;
            tx_act_ff <= nxt_tx_act;
        end
    end

    assign tx_pin = tx_sh_ff[0];
    assign tx_busy = tx_act_ff;
    assign rx_data = rx_sh_ff;
    assign rx_valid = rx_vld_ff;

    chk_tx_start_low: assert property (@(posedge clk_sys) disable iff (rst)
        (tx_start && !tx_act_ff) |=> !tx_pin) else $error("start bit not low");
endmodule // serial_byte_port

// ==== design/startup_sequencer.sv ====
/*
 * Start-up sequencer: settling, auto-baud handshake, splash decision,
 * auto-run launch, volume command check, ACK/NAK replies.
 * Assumes card_script_found is a level from card logic on clk_sys.
 */
`timescale 1ns/100ps
`include "startup_regs.svh"
module startup_sequencer
    import startup_pkg::*;
#(
    parameter int SETTLE_CYC = `SETTLE_CYCLES,
    parameter int SPLASH_CYC = `SPLASH_CYCLES,
    parameter int BIT_CYC = `BIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic card_script_found,
    output logic screen_blank,
    output logic splash_show,
    output logic autorun_start,
    output logic link_ready,
    output logic [6:0] volume,
    output logic audio_start,
    output logic firmware_load_req
);
    seq_state_t st_ff, nxt_st;
    cmd_state_t cp_ff, nxt_cp;
    logic [31:0] tmr_ff, nxt_tmr;
    logic blank_ff, nxt_blank, splash_ff, nxt_splash;
    logic autorun_ff, nxt_autorun, ready_ff, nxt_ready;
    logic [6:0] vol_ff, nxt_vol;
    logic aud_ff, nxt_aud, fw_ff, nxt_fw;
    logic [7:0] txd_ff, nxt_txd;
    logic txs_ff, nxt_txs;
    logic [7:0] rx_data;
    logic rx_valid, tx_busy, tx_raw;
    // Card pointer reach handed to card logic; raw access itself lives there
    localparam int CARD_BYTE_ADDR_W = 32;
    localparam int CARD_SECTOR_ADDR_W = 24;
    localparam int CARD_SECTOR_BYTES = 512;

    // Port always at the default rate; later rate changes live elsewhere
    serial_byte_port #(.BIT_CYC(BIT_CYC)) u_port (
        .clk_sys(clk_sys),
        .rst(rst),
        .rx_pin(rx_pin),
        .tx_pin(tx_raw),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .tx_data(txd_ff),
        .tx_start(txs_ff),
        .tx_busy(tx_busy)
    );

    // ****************
    // Start-up sequence
    // ****************
    always_comb begin
        nxt_st = st_ff;
        nxt_tmr = tmr_ff;
        nxt_blank = blank_ff;
        nxt_splash = splash_ff;
        nxt_autorun = 1'b0;
        nxt_ready = ready_ff;
        nxt_cp = cp_ff;
        nxt_vol = vol_ff;
        nxt_aud = 1'b0;
        nxt_fw = 1'b0;
        nxt_txd = txd_ff;
        nxt_txs = 1'b0;
        case (st_ff)
            ST_SETTLE: begin
                // Bytes received now are dropped; host is told to stay silent
                if (tmr_ff >= 32'(SETTLE_CYC - 1)) begin
                    nxt_st = ST_WAIT_BAUD;
                    nxt_tmr = 32'h0;
                    if (card_script_found) nxt_autorun = 1'b1;
                end else begin
                    nxt_tmr = tmr_ff + 32'h1;
                end
            end
            ST_WAIT_BAUD: begin
                nxt_blank = 1'b1;
                if (rx_valid && rx_data == `BYTE_AUTOBAUD) begin
                    nxt_st = ST_RUN;
                    nxt_ready = 1'b1;
                    nxt_txd = `BYTE_ACK;
                    nxt_txs = !tx_busy;
                end else if (tmr_ff >= 32'(SPLASH_CYC - 1)) begin
                    nxt_st = ST_SPLASH;
                    nxt_splash = 1'b1;
                    nxt_blank = 1'b0;
                end else begin
                    nxt_tmr = tmr_ff + 32'h1;
                end
            end
            ST_SPLASH: begin
                // Late auto-baud still opens the link; splash stays up
                if (rx_valid && rx_data == `BYTE_AUTOBAUD) begin
                    nxt_st = ST_RUN;
                    nxt_ready = 1'b1;
                    nxt_txd = `BYTE_ACK;
                    nxt_txs = !tx_busy;
                end
            end
            ST_RUN: begin
                if (rx_valid && !tx_busy) begin
                    nxt_txs = 1'b1;
                    nxt_txd = `BYTE_ACK;
                    case (cp_ff)
                        CP_VOLUME: begin
                            nxt_cp = CP_IDLE;
                            if (rx_data >= {1'b0, `VOL_MIN} && rx_data <= {1'b0, `VOL_MAX}) begin
                                nxt_vol = rx_data[6:0];
                            end else begin
                                nxt_txd = `BYTE_NAK;
                            end
                        end
                        default: begin
                            if (rx_data == `CMD_SET_VOLUME) begin
                                nxt_cp = CP_VOLUME;
                                nxt_txs = 1'b0;
                            end else if (rx_data == `CMD_PLAY_AUDIO) begin
                                // Pulse only; playback runs on without blocking commands
                                nxt_aud = 1'b1;
                            end else if (rx_data == `CMD_FW_LOAD) begin
                                nxt_fw = 1'b1;
                            end else if (rx_data != `BYTE_AUTOBAUD) begin
                                nxt_txd = `BYTE_NAK;
                            end
                        end
                    endcase
                end
            end
            default: nxt_st = ST_SETTLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= ST_SETTLE;
            cp_ff <= CP_IDLE;
            tmr_ff <= 32'h0;
            blank_ff <= 1'b1;
            splash_ff <= 1'b0;
            autorun_ff <= 1'b0;
            ready_ff <= 1'b0;
            vol_ff <= `VOL_RESET;
            aud_ff <= 1'b0;
            fw_ff <= 1'b0;
            txd_ff <= 8'h00;
            txs_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cp_ff <= nxt_cp;
            tmr_ff <= nxt_tmr;
            blank_ff <= nxt_blank;
            splash_ff <= nxt_splash;
            autorun_ff <= nxt_autorun;
            ready_ff <= nxt_ready;
            vol_ff <= nxt_vol;
            aud_ff <= nxt_aud;
            fw_ff <= nxt_fw;
            txd_ff <= nxt_txd;
            txs_ff <= nxt_txs;
        end
    end

    // Garbage is not sent while settling: TX held idle high
    assign tx_pin = (st_ff == ST_SETTLE) ? 1'b1 : tx_raw;
    assign screen_blank = blank_ff;
    assign splash_show = splash_ff;
    assign autorun_start = autorun_ff;
    assign link_ready = ready_ff;
    assign volume = vol_ff;
    assign audio_start = aud_ff;
    assign firmware_load_req = fw_ff;

    // ****************
    // Checks
    // ****************
    chk_volume_range: assert property (@(posedge clk_sys) disable iff (rst)
        (volume >= `VOL_MIN)) else $error("volume below minimum");
    chk_volume_reject: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_RUN && cp_ff == CP_VOLUME && rx_valid && !tx_busy
            && (rx_data < {1'b0, `VOL_MIN} || rx_data > {1'b0, `VOL_MAX}))
        |=> ($stable(volume) && txs_ff && txd_ff == `BYTE_NAK)) else $error("out-of-range volume taken");
    chk_volume_accept: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_RUN && cp_ff == CP_VOLUME && rx_valid && !tx_busy
            && rx_data >= {1'b0, `VOL_MIN} && rx_data <= {1'b0, `VOL_MAX})
        |=> (volume == $past(rx_data[6:0]) && txd_ff == `BYTE_ACK)) else $error("in-range volume lost");
    chk_splash_blank: assert property (@(posedge clk_sys) disable iff (rst)
        splash_show |-> !screen_blank) else $error("splash while blank");
    chk_splash_timeout: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_WAIT_BAUD && tmr_ff >= 32'(SPLASH_CYC - 1) && !rx_valid)
        |=> (splash_show && !screen_blank && !link_ready)) else $error("no splash after wait");
    chk_no_splash_early: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_WAIT_BAUD) |-> !splash_show) else $error("splash too early");
    chk_baud_ack: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_WAIT_BAUD && rx_valid && rx_data == `BYTE_AUTOBAUD && !tx_busy)
        |=> (txs_ff && txd_ff == `BYTE_ACK && link_ready)) else $error("no ack to auto-baud");
    chk_blank_after_baud: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_WAIT_BAUD && rx_valid && rx_data == `BYTE_AUTOBAUD)
        |=> (screen_blank && !splash_show)) else $error("screen not blank");
    chk_settle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_SETTLE) |-> (tx_pin && !link_ready)) else $error("active while settling");
    chk_autorun_once: assert property (@(posedge clk_sys) disable iff (rst)
        autorun_start |-> ($past(st_ff) == ST_SETTLE && st_ff == ST_WAIT_BAUD)) else $error("bad autorun");
    chk_unknown_nak: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_RUN && cp_ff == CP_IDLE && rx_valid && !tx_busy
            && !(rx_data inside {`CMD_SET_VOLUME, `CMD_PLAY_AUDIO, `CMD_FW_LOAD, `BYTE_AUTOBAUD}))
        |=> (txs_ff && txd_ff == `BYTE_NAK)) else $error("no nak to unknown");
    chk_audio_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_RUN && cp_ff == CP_IDLE && rx_valid && !tx_busy && rx_data == `CMD_PLAY_AUDIO)
        |=> (audio_start && st_ff == ST_RUN && txs_ff && txd_ff == `BYTE_ACK)) else $error("audio start lost");
    chk_fw_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == ST_RUN && cp_ff == CP_IDLE && rx_valid && !tx_busy && rx_data == `CMD_FW_LOAD)
        |=> (firmware_load_req && txd_ff == `BYTE_ACK)) else $error("firmware load request lost");
    chk_fw_serial_only: assert property (@(posedge clk_sys) disable iff (rst)
        firmware_load_req |-> ($past(rx_valid) && $past(rx_data) == `CMD_FW_LOAD && $past(st_ff) == ST_RUN))
        else $error("firmware load not from serial");
endmodule // startup_sequencer

// ==== verif/host_model.sv ====
/*
 * Host model: 8N1 serial sender and receiver standing on the far side of the link.
 * Assumes the bench clock is shared and one bit lasts BIT_CYC cycles.
 */
`timescale 1ns/100ps
module host_model #(
    parameter int BIT_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic rx_line,
    output logic tx_line
);
    // ****************************
    // Serial line tasks
    // ****************************
    initial tx_line = 1'b1;

    // Caller waits out settling before the first byte, at the default rate
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys);
            tx_line = frame[i];
            repeat (BIT_CYC - 1) @(negedge clk_sys);
        end
    endtask

    // Receiver is only opened after settling, so early noise is never seen
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        ok = 1'b0;
        while (rx_line === 1'b1 && n < 40 * BIT_CYC) begin
            @(negedge clk_sys);
            n++;
        end
        if (rx_line === 1'b0) begin
            repeat (BIT_CYC / 2) @(negedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(negedge clk_sys);
                b[i] = rx_line;
            end
            repeat (BIT_CYC) @(negedge clk_sys);
            ok = (rx_line === 1'b1);
        end
    endtask
endmodule // host_model

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the start-up sequencer, driving it through a host model.
 * Assumes shortened settle, splash and bit counts; inputs change on the falling edge.
 */
`timescale 1ns/100ps
`include "startup_regs.svh"
module tb_top;
    localparam int SETTLE = 50;
    localparam int SPLASH = 400;
    localparam int BITC = 8;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic card_script_found = 1'b0;
    logic rx_pin, tx_pin, screen_blank, splash_show, autorun_start, link_ready, audio_start, firmware_load_req;
    logic [6:0] volume;
    int err_count = 0;
    int compares = 0;
    int n_run = 0;
    int n_aud = 0;
    int n_fw = 0;

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        n_run <= n_run + int'(autorun_start === 1'b1);
        n_aud <= n_aud + int'(audio_start === 1'b1);
        n_fw <= n_fw + int'(firmware_load_req === 1'b1);
    end

    startup_sequencer #(.SETTLE_CYC(SETTLE), .SPLASH_CYC(SPLASH), .BIT_CYC(BITC)) startup_sequencer_i (
        .clk_sys(clk_sys), .rst(rst), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .card_script_found(card_script_found), .screen_blank(screen_blank), .splash_show(splash_show),
        .autorun_start(autorun_start), .link_ready(link_ready), .volume(volume),
        .audio_start(audio_start), .firmware_load_req(firmware_load_req));

    host_model #(.BIT_CYC(BITC)) host_model_i (.clk_sys(clk_sys), .rx_line(tx_pin), .tx_line(rx_pin));

    // ****************************
    // Shared tasks
    // ****************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset(input logic card);
        @(negedge clk_sys);
        rst = 1'b1;
        card_script_found = card;
        repeat (2) @(negedge clk_sys);
        check("tx idle", {7'h00, tx_pin}, 8'h01);
        check("blank at reset", {7'h00, screen_blank}, 8'h01);
        check("volume at reset", {1'b0, volume}, {1'b0, `VOL_RESET});
        rst = 1'b0;
    endtask

    // Reply is awaited alongside sending, since it may start before the stop bit ends
    task automatic xfer(input logic [7:0] b, input logic [7:0] exp, input string what);
        logic [7:0] r;
        logic ok;
        fork
            host_model_i.send_byte(b);
            host_model_i.recv_byte(r, ok);
        join
        check({what, " framed"}, {7'h00, ok}, 8'h01);
        check(what, r, exp);
    endtask

    // ****************************
    // Scenarios
    // ****************************
    task automatic t_splash;
        int r0;
        r0 = n_run;
        do_reset(1'b1);
        repeat (SPLASH - 20) @(negedge clk_sys);
        check("blank in wait", {7'h00, screen_blank}, 8'h01);
        check("no splash yet", {7'h00, splash_show}, 8'h00);
        check("autorun once", 8'(n_run - r0), 8'h01);
        repeat (SETTLE + 40) @(negedge clk_sys);
        check("splash shown", {7'h00, splash_show}, 8'h01);
        check("blank gone", {7'h00, screen_blank}, 8'h00);
        check("no link", {7'h00, link_ready}, 8'h00);
    endtask

    task automatic t_autobaud;
        int r0;
        logic [7:0] r;
        logic ok;
        do_reset(1'b0);
        r0 = n_run;
        repeat (SETTLE + 5) @(negedge clk_sys);
        fork
            host_model_i.send_byte(`BYTE_AUTOBAUD);
            host_model_i.recv_byte(r, ok);
        join
        if (ok !== 1'b1) begin
            xfer(`BYTE_AUTOBAUD, `BYTE_ACK, "autobaud retry");
        end else begin
            check("autobaud ack", r, `BYTE_ACK);
        end
        check("link ready", {7'h00, link_ready}, 8'h01);
        check("no autorun", 8'(n_run - r0), 8'h00);
        repeat (SPLASH) @(negedge clk_sys);
        check("still blank", {7'h00, screen_blank}, 8'h01);
        check("splash held off", {7'h00, splash_show}, 8'h00);
    endtask

    task automatic t_cmds;
        logic [7:0] cmd [4] = '{8'h6C, 8'h70, 8'h00, `BYTE_AUTOBAUD};
        logic [7:0] rep [4] = '{`BYTE_ACK, `BYTE_ACK, `BYTE_NAK, `BYTE_ACK};
        int a0;
        int f0;
        a0 = n_aud;
        f0 = n_fw;
        for (int i = 0; i < 4; i++) begin
            xfer(cmd[i], rep[i], "command reply");
        end
        check("audio pulse", 8'(n_aud - a0), 8'h01);
        check("firmware pulse", 8'(n_fw - f0), 8'h01);
    endtask

    // Volume follows the audio start, so playback must not block commands
    task automatic t_volume;
        logic [7:0] val [5] = '{8'h07, 8'h08, 8'h80, 8'h7F, 8'h00};
        logic [7:0] ev;
        logic good;
        ev = {1'b0, `VOL_RESET};
        for (int i = 0; i < 5; i++) begin
            good = (val[i] >= 8'h08 && val[i] <= 8'h7F);
            host_model_i.send_byte(`CMD_SET_VOLUME);
            xfer(val[i], good ? `BYTE_ACK : `BYTE_NAK, "volume reply");
            if (good) begin
                ev = val[i];
            end
            check("volume level", {1'b0, volume}, ev);
        end
    endtask

    // ****************************
    // Run control
    // ****************************
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("watchdog expired before tests ended");
        final_report();
    end

    initial begin
        t_splash();
        t_autobaud();
        t_cmds();
        t_volume();
        final_report();
    end
endmodule // tb_top
